/* core/pfc_pkg.sv */
// package: constants for the parallel flash host controller
package pfc_pkg;
  localparam int PFC_AW = 17;
  localparam int PFC_DW = 8;
  // apb register offsets
  localparam logic [7:0] PFC_REG_CTRL = 8'h00;
  localparam logic [7:0] PFC_REG_ADDR = 8'h04;
  localparam logic [7:0] PFC_REG_WDATA = 8'h08;
  localparam logic [7:0] PFC_REG_STATUS = 8'h0C;
  localparam logic [7:0] PFC_REG_RDATA = 8'h10;
  // ctrl command field, bits 2:0, start pulse bit 31
  localparam int PFC_CTRL_START = 31;
  localparam int PFC_CTRL_HV = 8;
  localparam logic [2:0] PFC_CMD_READ = 3'h0;
  localparam logic [2:0] PFC_CMD_PROG = 3'h1;
  localparam logic [2:0] PFC_CMD_ID_ENTER = 3'h2;
  localparam logic [2:0] PFC_CMD_ID_EXIT = 3'h3;
  localparam logic [2:0] PFC_CMD_ID_EXIT1 = 3'h4;
  localparam logic [2:0] PFC_CMD_WRITE = 3'h5;
  // status bits
  localparam int PFC_ST_BUSY = 0;
  localparam int PFC_ST_DONE = 1;
  localparam int PFC_ST_FAIL = 2;
  localparam int PFC_ST_PARITY = 3;
  localparam int PFC_ST_READY = 4;
  // command sequence values
  localparam logic [16:0] PFC_UNLOCK_A1 = 17'h05555;
  localparam logic [16:0] PFC_UNLOCK_A2 = 17'h02AAA;
  localparam logic [7:0] PFC_UNLOCK_D1 = 8'hAA;
  localparam logic [7:0] PFC_UNLOCK_D2 = 8'h55;
  localparam logic [7:0] PFC_SETUP_PROG = 8'hA0;
  localparam logic [7:0] PFC_SETUP_ID = 8'h90;
  localparam logic [7:0] PFC_SETUP_EXIT = 8'hF0;
  // id and lock addresses
  localparam logic [16:0] PFC_ID_MAKER = 17'h00000;
  localparam logic [16:0] PFC_ID_PART = 17'h00001;
  localparam logic [16:0] PFC_LOCK_BOT = 17'h00002;
  localparam logic [16:0] PFC_LOCK_TOP = 17'h1FFF2;
  localparam int PFC_POLL_BIT = 7;
  localparam int PFC_TOGGLE_BIT = 6;
  // timing
  localparam int PFC_CLK_NS = 25;
  localparam int PFC_STROBE_NS = 50;
  localparam int PFC_STROBE_CYC =
    (PFC_STROBE_NS + PFC_CLK_NS - 1) / PFC_CLK_NS;
  localparam int PFC_PWRUP_MS = 5;
  localparam int PFC_PWRUP_CYC = PFC_PWRUP_MS * 1000000 / PFC_CLK_NS;
  localparam int PFC_POLL_MAX = 4096;
  typedef enum logic [3:0] {
    PFC_IDLE, PFC_PWR, PFC_LOAD, PFC_BUSW, PFC_NEXT, PFC_BUSR,
    PFC_POLL, PFC_POLLW, PFC_FIN
  } pfc_state_type;
endpackage

/* core/pfc_buscycle.sv */
// module: one timed write or read cycle on the flash pins
`timescale 1ns/1ps
module pfc_buscycle
  import pfc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic is_write,
  input wire logic [PFC_AW-1:0] addr,
  input wire logic [PFC_DW-1:0] wdata,
  input wire logic [PFC_DW-1:0] dq_in,
  output logic done,
  output logic [PFC_DW-1:0] rdata,
  output logic [PFC_AW-1:0] flash_addr,
  output logic [PFC_DW-1:0] dq_out,
  output logic dq_oe,
  output logic ce_n,
  output logic oe_n,
  output logic we_n
);
  localparam logic [3:0] STROBE = 4'(PFC_STROBE_CYC);
  logic [3:0] cnt_q;
  logic [1:0] ph_q;
  logic wr_q;
  logic [PFC_DW-1:0] s1_q;
  logic [PFC_DW-1:0] s2_q;

  // dq pins are async to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
    end else begin
      s1_q <= dq_in;
      s2_q <= s1_q;
    end
  end

  // phases: 0 idle, 1 setup, 2 strobe, 3 hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 2'd0;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      flash_addr <= '0;
      dq_out <= 8'h00;
      rdata <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (ph_q)
        2'd0: if (start) begin
          ph_q <= 2'd1;
          wr_q <= is_write;
          flash_addr <= addr;
          dq_out <= wdata;
          cnt_q <= 4'h0;
        end
        2'd1: ph_q <= 2'd2;
        // strobe held well past the glitch filter width
        2'd2: if (cnt_q == STROBE + 4'h2) begin
          ph_q <= 2'd3;
          rdata <= s2_q;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
        default: begin
          ph_q <= 2'd0;
          done <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    ce_n = !(ph_q == 2'd1 || ph_q == 2'd2 || ph_q == 2'd3);
    we_n = !(wr_q && ph_q == 2'd2);
    oe_n = !(!wr_q && ph_q == 2'd2);
    dq_oe = wr_q && ph_q != 2'd0;
  end
endmodule

/* core/pfc_host.sv */
// module: apb-controlled host for a byte-wide parallel flash
`timescale 1ns/1ps
module pfc_host
  import pfc_pkg::*;
#(
  parameter int PWRUP_CYC = PFC_PWRUP_CYC,
  parameter int POLL_MAX = PFC_POLL_MAX
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [PFC_AW-1:0] flash_addr,
  input wire logic [PFC_DW-1:0] dq_in,
  output logic [PFC_DW-1:0] dq_out,
  output logic dq_oe,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic id_high_voltage_pin
);
  pfc_state_type st_q;
  logic [2:0] cmd_q;
  logic [PFC_AW-1:0] addr_q;
  logic [7:0] wdat_q;
  logic [7:0] rdat_q;
  logic hv_q;
  logic busy_q;
  logic done_q;
  logic fail_q;
  logic [2:0] step_q;
  logic [22:0] pwr_q;
  logic [15:0] poll_q;
  logic go_q;
  logic go_wr_q;
  logic [PFC_AW-1:0] go_addr_q;
  logic [7:0] go_dat_q;
  logic cyc_done;
  logic [7:0] cyc_rdata;
  logic wr_ctrl;
  logic [2:0] nsteps;

  function automatic logic odd_par(input logic [7:0] v);
    return ^v;
  endfunction

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_ctrl = psel && penable && pwrite && paddr == PFC_REG_CTRL;
  assign id_high_voltage_pin = hv_q;
  assign nsteps = (cmd_q == PFC_CMD_PROG || cmd_q == PFC_CMD_ID_ENTER ||
    cmd_q == PFC_CMD_ID_EXIT) ? 3'd3 : 3'd0;

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      PFC_REG_CTRL: prdata = {23'h0, hv_q, 5'h0, cmd_q};
      PFC_REG_ADDR: prdata = {15'h0, addr_q};
      PFC_REG_WDATA: prdata = {24'h0, wdat_q};
      PFC_REG_STATUS: prdata = {27'h0, st_q == PFC_IDLE,
        odd_par(rdat_q), fail_q, done_q, busy_q};
      PFC_REG_RDATA: prdata = {24'h0, rdat_q};
      default: prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= PFC_CMD_READ;
      addr_q <= '0;
      wdat_q <= 8'h00;
      hv_q <= 1'b0;
    end else if (psel && penable && pwrite && !busy_q) begin
      case (paddr)
        PFC_REG_CTRL: begin
          cmd_q <= pwdata[2:0];
          hv_q <= pwdata[PFC_CTRL_HV];
        end
        PFC_REG_ADDR: addr_q <= pwdata[PFC_AW-1:0];
        PFC_REG_WDATA: wdat_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // sequencer for unlock, set-up, data, then poll
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= PFC_PWR;
      pwr_q <= '0;
      busy_q <= 1'b1;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      step_q <= 3'd0;
      poll_q <= '0;
      rdat_q <= 8'h00;
      go_q <= 1'b0;
      go_wr_q <= 1'b0;
      go_addr_q <= '0;
      go_dat_q <= 8'h00;
    end else begin
      go_q <= 1'b0;
      case (st_q)
        PFC_PWR: if (pwr_q == 23'(PWRUP_CYC - 1)) begin
          st_q <= PFC_IDLE;
          busy_q <= 1'b0;
        end else begin
          pwr_q <= pwr_q + 23'h1;
        end
        PFC_IDLE: if (wr_ctrl && pwdata[PFC_CTRL_START]) begin
          st_q <= PFC_LOAD;
          busy_q <= 1'b1;
          step_q <= 3'd0;
          poll_q <= '0;
          fail_q <= 1'b0;
        end
        PFC_LOAD: begin
          go_q <= 1'b1;
          go_wr_q <= 1'b1;
          st_q <= PFC_BUSW;
          // exit by three writes or one
          if (step_q == 3'd0 && nsteps != 3'd0) begin
            go_addr_q <= PFC_UNLOCK_A1;
            go_dat_q <= PFC_UNLOCK_D1;
          end else if (step_q == 3'd1) begin
            go_addr_q <= PFC_UNLOCK_A2;
            go_dat_q <= PFC_UNLOCK_D2;
          end else if (step_q == 3'd2) begin
            go_addr_q <= PFC_UNLOCK_A1;
            go_dat_q <= cmd_q == PFC_CMD_PROG ? PFC_SETUP_PROG :
              cmd_q == PFC_CMD_ID_ENTER ? PFC_SETUP_ID : PFC_SETUP_EXIT;
          end else if (cmd_q == PFC_CMD_ID_EXIT1) begin
            go_addr_q <= addr_q;
            go_dat_q <= PFC_SETUP_EXIT;
          end else if (cmd_q == PFC_CMD_PROG ||
              cmd_q == PFC_CMD_WRITE) begin
            go_addr_q <= addr_q;
            go_dat_q <= wdat_q;
          end else begin
            // read, also covers id and lock reads
            go_wr_q <= 1'b0;
            // page bit held low while the id pin is raised
            go_addr_q <= hv_q ? {addr_q[PFC_AW-1:2], 1'b0, addr_q[0]} :
              addr_q;
            go_q <= cmd_q == PFC_CMD_READ;
            st_q <= cmd_q == PFC_CMD_READ ? PFC_BUSR : PFC_FIN;
          end
        end
        PFC_BUSW: if (cyc_done) begin
          st_q <= PFC_NEXT;
        end
        PFC_NEXT: if (step_q < nsteps) begin
          step_q <= step_q + 3'd1;
          st_q <= (step_q + 3'd1 == nsteps && cmd_q != PFC_CMD_PROG) ?
            PFC_FIN : PFC_LOAD;
        end else if (cmd_q == PFC_CMD_PROG) begin
          st_q <= PFC_POLL;
        end else begin
          st_q <= PFC_FIN;
        end
        PFC_BUSR: if (cyc_done) begin
          rdat_q <= cyc_rdata;
          st_q <= PFC_FIN;
        end
        PFC_POLL: begin
          go_q <= 1'b1;
          go_wr_q <= 1'b0;
          go_addr_q <= addr_q;
          st_q <= PFC_POLLW;
        end
        PFC_POLLW: if (cyc_done) begin
          rdat_q <= cyc_rdata;
          poll_q <= poll_q + 16'h1;
          if (cyc_rdata[PFC_POLL_BIT] == wdat_q[PFC_POLL_BIT]) begin
            st_q <= PFC_FIN;
          end else if (poll_q == 16'(POLL_MAX - 1)) begin
            fail_q <= 1'b1;
            st_q <= PFC_FIN;
          end else begin
            st_q <= PFC_POLL;
          end
        end
        PFC_FIN: begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          st_q <= PFC_IDLE;
        end
        default: st_q <= PFC_IDLE;
      endcase
      if (st_q == PFC_IDLE && wr_ctrl && pwdata[PFC_CTRL_START]) begin
        done_q <= 1'b0;
      end
    end
  end

  pfc_buscycle u_cyc (
    .pclk(pclk),
    .presetn(presetn),
    .start(go_q),
    .is_write(go_wr_q),
    .addr(go_addr_q),
    .wdata(go_dat_q),
    .dq_in(dq_in),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .ce_n(ce_n),
    .oe_n(oe_n),
    .we_n(we_n)
  );
endmodule

/* tb/pfc_host_properties.sv */
// checker for the flash host pins
`timescale 1ns/1ps
module pfc_host_properties
  import pfc_pkg::*;
#(
  parameter int PWRUP_CYC = PFC_PWRUP_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [PFC_AW-1:0] flash_addr,
  input wire logic [PFC_DW-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n
);
  int cnt_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // saturates, so no wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= 0;
    else if (cnt_q < PWRUP_CYC) cnt_q <= cnt_q + 1;
  end
  a_oe_needs_ce: assert property (!oe_n |-> !ce_n)
    else $error("gate low while deselected");
  a_write_inhibit: assert property (!we_n |-> !ce_n && oe_n)
    else $error("bad write strobe");
  a_drive_only: assert property (dq_oe |-> !ce_n && oe_n)
    else $error("drives bus outside write");
  a_float_idle: assert property (ce_n |-> !dq_oe && oe_n && we_n)
    else $error("active while deselected");
  a_addr_steady: assert property (!we_n && !$past(we_n) |->
    $stable(flash_addr) && $stable(dq_out)) else $error("moved in strobe");
  a_ce_leads: assert property ($fell(we_n) |-> !$past(ce_n))
    else $error("strobe before select");
  a_we_width: assert property ($fell(we_n) |-> !we_n [*4])
    else $error("strobe too short");
  a_ce_holds: assert property ($rose(we_n) |-> !ce_n)
    else $error("select left before strobe");
  a_pwrup_hold: assert property (!we_n |-> cnt_q == PWRUP_CYC)
    else $error("write before power-up delay");
endmodule
bind pfc_host pfc_host_properties #(.PWRUP_CYC(PWRUP_CYC)) i_props (
  .pclk(pclk), .presetn(presetn), .flash_addr(flash_addr),
  .dq_out(dq_out), .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));

/* tb/pfc_flash_model.sv */
// behavioural flash device
`timescale 1ns/1ps
module pfc_flash_model #(
  // arbitrary id codes, odd parity
  parameter logic [7:0] MAKER = 8'h8C,
  parameter logic [7:0] PART = 8'h9E,
  parameter int TICKS = 40
)
(
  input wire logic [16:0] a,
  input wire logic [7:0] d,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic hv,
  output logic [7:0] q
);
  logic [7:0] mem [logic [16:0]];
  logic [7:0] rv, wd = 8'h00, hold = 8'h00;
  logic [16:0] al = 17'h0;
  logic busy = 0, idm = 0, tg = 0;
  int st = 0;
  always @* begin
    if (busy) rv = {~wd[7], tg, 6'h00};
    else if (hv && !a[1]) rv = a[0] ? PART : MAKER;
    else if (idm) rv = a == 17'h2 ? 8'h03 : a == 17'h1FFF2 ? 8'h00 :
      a[7:0] == 8'h0 ? MAKER : a[7:0] == 8'h1 ? PART : 8'h00;
    else rv = mem.exists(a) ? mem[a] : 8'hFF;
  end
  assign q = (!ce_n && !oe_n) ? rv : ~hold;
  always @(posedge oe_n) hold = rv;
  always @(negedge oe_n) if (!ce_n && busy) tg = !tg;
  always @(negedge we_n) al = a;
  always @(posedge we_n) if (!ce_n && oe_n && !busy) begin
    if (st == 3) begin
      st = 0;
      if (al > 17'h01FFF) begin
        wd = d;
        mem[al] = (mem.exists(al) ? mem[al] : 8'hFF) & d;
        busy = 1;
        fork begin #(TICKS * 25); busy = 0; end join_none
      end
    end else if (st == 0 && al == 17'h05555 && d == 8'hAA) st = 1;
    else if (st == 1 && al == 17'h02AAA && d == 8'h55) st = 2;
    else if (st == 2 && al == 17'h05555 && d == 8'hA0) st = 3;
    else begin
      if (st == 2 && al == 17'h05555 && d == 8'h90) idm = 1;
      if (d == 8'hF0) idm = 0;
      st = 0;
    end
  end
endmodule

/* tb/tb_pfc_host.sv */
// bench for the flash host
`timescale 1ns/1ps
module tb_pfc_host;
  import pfc_pkg::*;
  localparam logic [7:0] MK = 8'h8C;
  localparam logic [7:0] PT = 8'h9E;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, dq_out, q, bus, d;
  logic [31:0] pwdata = 32'h0, prdata, st, r;
  logic pready, dq_oe, ce_n, oe_n, we_n, hv;
  logic [16:0] fa, a;
  int num_errors = 0, cmp_count = 0;
  assign bus = dq_oe ? dq_out : q;
  pfc_host #(.PWRUP_CYC(10)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
    .flash_addr(fa), .dq_in(bus), .dq_out(dq_out), .dq_oe(dq_oe),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .id_high_voltage_pin(hv));
  pfc_flash_model #(.MAKER(MK), .PART(PT)) i_mem (.a(fa), .d(bus),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .hv(hv), .q(q));
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  task automatic apb(input logic w, input logic [7:0] ad,
      input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0; penable <= 0;
  endtask
  task automatic op(input logic [2:0] c, input logic [16:0] ad,
      input logic [7:0] wd, input logic h);
    int n;
    apb(1, PFC_REG_ADDR, {15'h0, ad});
    apb(1, PFC_REG_WDATA, {24'h0, wd});
    apb(1, PFC_REG_CTRL, {23'h400000, h, 5'h0, c});
    n = 0;
    do begin apb(0, PFC_REG_STATUS, 32'h0); n++; end
    while (r[PFC_ST_BUSY] !== 1'b0 && n < 20000);
    // a command that never finishes counts as a mismatch
    if (r[PFC_ST_BUSY] !== 1'b0) num_errors++;
    st = r;
    apb(0, PFC_REG_RDATA, 32'h0);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
      num_errors++;
    end
  endtask
  function automatic logic [7:0] prog_exp(input logic [7:0] o, n);
    return o & n;
  endfunction
  task automatic summarize();
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(69510));
    repeat (10) @(posedge pclk);
    presetn <= 1;
    r = 0;
    while (r[PFC_ST_READY] !== 1'b1) apb(0, PFC_REG_STATUS, 32'h0);
    a = 17'h02000 + 17'($urandom % 32'h1C000);
    d = (8'($urandom) & 8'h7F) | 8'h01;
    op(PFC_CMD_READ, a, 8'h00, 0);
    chk(r[7:0], 8'hFF);
    op(PFC_CMD_PROG, a, d, 0);
    chk({6'h0, st[2:1]}, 8'h01);
    op(PFC_CMD_READ, a, 8'h00, 0);
    chk(r[7:0], prog_exp(8'hFF, d));
    op(PFC_CMD_PROG, a, d | 8'h80, 0);
    chk({7'h0, st[PFC_ST_FAIL]}, 8'h01);
    op(PFC_CMD_PROG, 17'h00100, 8'h8B, 0);
    op(PFC_CMD_READ, 17'h00100, 8'h00, 0);
    chk(r[7:0], 8'hFF);
    // broken unlock, then what would program
    op(PFC_CMD_WRITE, PFC_UNLOCK_A1, PFC_UNLOCK_D1, 0);
    op(PFC_CMD_WRITE, PFC_UNLOCK_A2, 8'h12, 0);
    op(PFC_CMD_WRITE, PFC_UNLOCK_A1, PFC_SETUP_PROG, 0);
    op(PFC_CMD_WRITE, a, 8'h00, 0);
    op(PFC_CMD_READ, a, 8'h00, 0);
    chk(r[7:0], d);
    for (int i = 0; i < 2; i++) begin
      op(PFC_CMD_ID_ENTER, 17'h0, 8'h00, 0);
      op(PFC_CMD_READ, PFC_ID_MAKER, 8'h00, 0);
      chk(r[7:0], MK);
      chk({7'h0, st[PFC_ST_PARITY]}, 8'h01);
      op(PFC_CMD_READ, PFC_ID_PART, 8'h00, 0);
      chk(r[7:0], PT);
      op(PFC_CMD_READ, PFC_LOCK_BOT, 8'h00, 0);
      chk(r[7:0] & 8'h03, 8'h03);
      op(PFC_CMD_READ, PFC_LOCK_TOP, 8'h00, 0);
      chk(r[7:0] & 8'h03, 8'h00);
      op(i ? PFC_CMD_ID_EXIT1 : PFC_CMD_ID_EXIT, 17'h0, 8'h00, 0);
      op(PFC_CMD_READ, a, 8'h00, 0);
      chk(r[7:0], d);
      op(PFC_CMD_READ, 17'h00002 | 17'(i), 8'h00, 1);
      chk(r[7:0], i ? PT : MK);
    end
    summarize();
  end
  // failed poll run is the longest case
  initial begin
    #(25 * 90000);
    num_errors++;
    summarize();
  end
endmodule
